// ---- verilog/tcp_regs.vh ----
// register indices, field positions, mode codes and reset values of the dual timer block
`ifndef TCP_REGS_VH
`define TCP_REGS_VH

// register indices; byte address on the bus is four times the index
`define TCP_IDX_T0_CNTH 12'hF00
`define TCP_IDX_T0_CNTL 12'hF01
`define TCP_IDX_T0_RLDH 12'hF02
`define TCP_IDX_T0_RLDL 12'hF03
`define TCP_IDX_T0_CMPH 12'hF04
`define TCP_IDX_T0_CMPL 12'hF05
`define TCP_IDX_T0_CTL1 12'hF07
`define TCP_IDX_T1_CNTH 12'hF08
`define TCP_IDX_T1_CNTL 12'hF09
`define TCP_IDX_T1_RLDH 12'hF0A
`define TCP_IDX_T1_RLDL 12'hF0B
`define TCP_IDX_T1_CMPH 12'hF0C
`define TCP_IDX_T1_CMPL 12'hF0D
`define TCP_IDX_T1_CTL1 12'hF0F
`define TCP_IDX_STATUS 12'hF10
`define TCP_IDX_MASK 12'hF11

// control register fields
`define TCP_CTL_EN 7
`define TCP_CTL_POL 6
`define TCP_CTL_PRESCALE_HI 5
`define TCP_CTL_PRESCALE_LO 3
`define TCP_CTL_MODE_HI 2
`define TCP_CTL_MODE_LO 0

// operating_mode_select codes
`define TCP_MODE_ONESHOT 3'h0
`define TCP_MODE_CONT 3'h1
`define TCP_MODE_COUNTER 3'h2
`define TCP_MODE_PWM 3'h3
`define TCP_MODE_CAPTURE 3'h4
`define TCP_MODE_COMPARE 3'h5
`define TCP_MODE_CAPCMP 3'h6

// status and mask bit positions inside one timer nibble
`define TCP_ST_RELOAD 0
`define TCP_ST_COMPARE 1
`define TCP_ST_CAPTURE 2
`define TCP_ST_CAPFLAG 3
`define TCP_ST_T1_BASE 4
// live capture flag bits are status only and never reach the interrupt
`define TCP_ST_IRQ_MASK 8'h77

// reset and load values
`define TCP_RST_BYTE 8'h00
`define TCP_RST_WORD 16'h0000
`define TCP_RST_RELOAD 16'hFFFF
`define TCP_CNT_START 16'h0001
`define TCP_PRE_ONE 8'h01
`define TCP_PRE_ZERO 7'h00

`endif

// ---- verilog/tcp_timer.v ----
// dual 16-bit timer with compare, capture and pwm output behind an ahb-lite slave
`timescale 1ns/100ps
`include "tcp_regs.vh"

// one timer channel: control, prescaler, count, compare/capture, output pin
module tcp_timer_ch
(
    input wire i_clk,
    input wire i_arst_n,
    input wire i_tin,
    input wire [7:0] i_wdata,
    input wire i_we_ctl,
    input wire i_we_cmph,
    input wire i_we_cmpl,
    input wire i_we_rldh,
    input wire i_we_rldl,
    output wire [7:0] o_ctl,
    output wire [15:0] o_cmp,
    output wire [15:0] o_rld,
    output wire [15:0] o_cnt,
    output wire o_tout,
    output wire o_capflag,
    output wire o_ev_reload,
    output wire o_ev_compare,
    output wire o_ev_capture
);
    reg [7:0] ctl_ff;
    reg [7:0] nxt_ctl;
    reg [15:0] cmp_ff;
    reg [15:0] nxt_cmp;
    reg [15:0] rld_ff;
    reg [15:0] nxt_rld;
    reg [15:0] cnt_ff;
    reg [15:0] nxt_cnt;
    reg [6:0] pre_ff;
    reg [6:0] nxt_pre;
    reg tin_prev_ff;
    reg tout_ff;
    reg nxt_tout;
    reg capflag_ff;
    reg nxt_capflag;
    wire en;
    wire pol;
    wire [2:0] prescale_select;
    wire [2:0] mode;
    wire [7:0] pre_top;
    wire tick;
    wire edge_sel;
    wire step;
    wire reload;
    wire [15:0] cnt_inc;
    wire cmp_mode;
    wire hit;
    wire capture;
    wire rel_toggle;

    assign en = ctl_ff[`TCP_CTL_EN];
    assign pol = ctl_ff[`TCP_CTL_POL];
    assign prescale_select = ctl_ff[`TCP_CTL_PRESCALE_HI:`TCP_CTL_PRESCALE_LO];
    assign mode = ctl_ff[`TCP_CTL_MODE_HI:`TCP_CTL_MODE_LO];

    // divide by two to the power of the code, so 110 gives 64 and 111 gives 128
    assign pre_top = (`TCP_PRE_ONE << prescale_select) - `TCP_PRE_ONE;
    assign tick = ({1'b0, pre_ff} == pre_top);

    // input is already synchronised; the edge detector looks only at the settled copy
    assign edge_sel = pol ? (tin_prev_ff & ~i_tin) : (~tin_prev_ff & i_tin);

    // counter mode steps on input edges, every other mode on prescaler ticks
    assign step = en & ((mode == `TCP_MODE_COUNTER) ? edge_sel : tick);
    assign reload = step & (cnt_ff == rld_ff);
    assign cnt_inc = cnt_ff + `TCP_CNT_START;

    // compare is judged on the value the count is about to take
    assign cmp_mode = (mode == `TCP_MODE_PWM) | (mode == `TCP_MODE_COMPARE)
                      | (mode == `TCP_MODE_CAPCMP);
    assign hit = step & ~reload & cmp_mode & (cnt_inc == cmp_ff);
    assign capture = en & edge_sel
                     & ((mode == `TCP_MODE_CAPTURE) | (mode == `TCP_MODE_CAPCMP));
    assign rel_toggle = reload & ((mode == `TCP_MODE_ONESHOT) | (mode == `TCP_MODE_CONT)
                                  | (mode == `TCP_MODE_COUNTER) | (mode == `TCP_MODE_PWM));

    // prescaler restarts on each tick and stays cleared while disabled
    always @*
    begin
        if (!en | tick)
            nxt_pre = `TCP_PRE_ZERO;
        else
            nxt_pre = pre_ff + 7'h01;
    end

    // count holds while disabled and restarts at one after reaching the reload value
    always @*
    begin
        if (reload)
            nxt_cnt = `TCP_CNT_START;
        else if (step)
            nxt_cnt = cnt_inc;
        else
            nxt_cnt = cnt_ff;
    end

    // software write wins over the one-shot self-disable so a restart is never lost
    always @*
    begin
        nxt_ctl = ctl_ff;
        if (i_we_ctl)
            nxt_ctl = i_wdata;
        else if (reload & (mode == `TCP_MODE_ONESHOT))
            nxt_ctl[`TCP_CTL_EN] = 1'b0;
    end

    // capture overrides a software write in the same cycle, the hardware value is newer
    always @*
    begin
        nxt_cmp = cmp_ff;
        if (capture)
            nxt_cmp = cnt_ff;
        else if (i_we_cmph)
            nxt_cmp = {i_wdata, cmp_ff[7:0]};
        else if (i_we_cmpl)
            nxt_cmp = {cmp_ff[15:8], i_wdata};
    end

    // reload value bytes
    always @*
    begin
        nxt_rld = rld_ff;
        if (i_we_rldh)
            nxt_rld = {i_wdata, rld_ff[7:0]};
        else if (i_we_rldl)
            nxt_rld = {rld_ff[15:8], i_wdata};
    end

    // output pin: polarity level while idle, while running toggles on compare, and on reload except in capture, compare and capcmp modes
    always @*
    begin
        if (!en)
            nxt_tout = pol;
        else if (rel_toggle ^ hit)
            nxt_tout = ~tout_ff;
        else
            nxt_tout = tout_ff;
    end

    // capture beats a simultaneous reload or compare event when naming the source
    always @*
    begin
        if (capture)
            nxt_capflag = 1'b1;
        else if (reload | hit)
            nxt_capflag = 1'b0;
        else
            nxt_capflag = capflag_ff;
    end

    // channel state
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctl_ff <= `TCP_RST_BYTE;
            cmp_ff <= `TCP_RST_WORD;
            rld_ff <= `TCP_RST_RELOAD;
            cnt_ff <= `TCP_RST_WORD;
            pre_ff <= `TCP_PRE_ZERO;
            tin_prev_ff <= 1'b0;
            tout_ff <= 1'b0;
            capflag_ff <= 1'b0;
        end
        else
        begin
            ctl_ff <= nxt_ctl;
            cmp_ff <= nxt_cmp;
            rld_ff <= nxt_rld;
            cnt_ff <= nxt_cnt;
            pre_ff <= nxt_pre;
            tin_prev_ff <= i_tin;
            tout_ff <= nxt_tout;
            capflag_ff <= nxt_capflag;
        end
    end

    assign o_ctl = ctl_ff;
    assign o_cmp = cmp_ff;
    assign o_rld = rld_ff;
    assign o_cnt = cnt_ff;
    assign o_tout = tout_ff;
    assign o_capflag = capflag_ff;
    assign o_ev_reload = reload;
    assign o_ev_compare = hit;
    assign o_ev_capture = capture;
endmodule

// top: ahb-lite register slave, input synchronisers, two timers, interrupt logic
module tcp_timer
(
    input wire I_CLK_SYS,
    input wire I_ARST_N,
    input wire I_HSEL,
    input wire [31:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [2:0] I_HSIZE,
    input wire [31:0] I_HWDATA,
    input wire I_HREADY,
    input wire I_TIN0,
    input wire I_TIN1,
    output wire [31:0] O_HRDATA,
    output wire O_HREADYOUT,
    output wire O_HRESP,
    output wire O_TOUT0,
    output wire O_TOUT1,
    output wire O_IRQ
);
    reg [1:0] tin0_sync_ff;
    reg [1:0] tin1_sync_ff;
    reg wr_pend_ff;
    reg rd_pend_ff;
    reg [11:0] idx_ff;
    reg [31:0] hrdata_ff;
    reg [7:0] status_ff;
    reg [7:0] nxt_status;
    reg [7:0] mask_ff;
    reg irq_ff;
    reg [7:0] rd_mux;
    wire accept;
    wire [11:0] idx_in;
    wire idx_ok;
    wire [7:0] wd;
    wire [7:0] ctl0;
    wire [7:0] ctl1;
    wire [15:0] cmp0;
    wire [15:0] cmp1;
    wire [15:0] rld0;
    wire [15:0] rld1;
    wire [15:0] cnt0;
    wire [15:0] cnt1;
    wire cap0;
    wire cap1;
    wire [2:0] ev0;
    wire [2:0] ev1;
    wire [7:0] ev_set;

    // address phase is taken only for a selected non-idle transfer at a word address
    assign idx_in = I_HADDR[13:2];
    assign idx_ok = (I_HADDR[31:14] == 18'h00000) & (I_HADDR[1:0] == 2'h0);
    assign accept = I_HSEL & I_HTRANS[1] & I_HREADY & idx_ok;
    assign wd = I_HWDATA[7:0];

    // two-flop synchronisers; only the second stage feeds the channels
    always @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            tin0_sync_ff <= 2'h0;
            tin1_sync_ff <= 2'h0;
        end
        else
        begin
            tin0_sync_ff <= {tin0_sync_ff[0], I_TIN0};
            tin1_sync_ff <= {tin1_sync_ff[0], I_TIN1};
        end
    end

    // reads take one wait state so read data comes from a flop and sees a just-written value
    always @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            idx_ff <= 12'h000;
            hrdata_ff <= 32'h00000000;
        end
        else
        begin
            if (rd_pend_ff)
            begin
                rd_pend_ff <= 1'b0;
                hrdata_ff <= {24'h000000, rd_mux};
            end
            else
            begin
                wr_pend_ff <= accept & I_HWRITE;
                rd_pend_ff <= accept & ~I_HWRITE;
                if (accept)
                    idx_ff <= idx_in;
            end
        end
    end

    // read mux over the latched index; unmapped indices read zero
    always @*
    begin
        case (idx_ff)
            `TCP_IDX_T0_CNTH: rd_mux = cnt0[15:8];
            `TCP_IDX_T0_CNTL: rd_mux = cnt0[7:0];
            `TCP_IDX_T0_RLDH: rd_mux = rld0[15:8];
            `TCP_IDX_T0_RLDL: rd_mux = rld0[7:0];
            `TCP_IDX_T0_CMPH: rd_mux = cmp0[15:8];
            `TCP_IDX_T0_CMPL: rd_mux = cmp0[7:0];
            `TCP_IDX_T0_CTL1: rd_mux = ctl0;
            `TCP_IDX_T1_CNTH: rd_mux = cnt1[15:8];
            `TCP_IDX_T1_CNTL: rd_mux = cnt1[7:0];
            `TCP_IDX_T1_RLDH: rd_mux = rld1[15:8];
            `TCP_IDX_T1_RLDL: rd_mux = rld1[7:0];
            `TCP_IDX_T1_CMPH: rd_mux = cmp1[15:8];
            `TCP_IDX_T1_CMPL: rd_mux = cmp1[7:0];
            `TCP_IDX_T1_CTL1: rd_mux = ctl1;
            `TCP_IDX_STATUS: rd_mux = status_ff;
            `TCP_IDX_MASK: rd_mux = mask_ff;
            default: rd_mux = `TCP_RST_BYTE;
        endcase
    end

    tcp_timer_ch u_ch0
    (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_tin(tin0_sync_ff[1]),
        .i_wdata(wd),
        .i_we_ctl(wr_pend_ff & (idx_ff == `TCP_IDX_T0_CTL1)),
        .i_we_cmph(wr_pend_ff & (idx_ff == `TCP_IDX_T0_CMPH)),
        .i_we_cmpl(wr_pend_ff & (idx_ff == `TCP_IDX_T0_CMPL)),
        .i_we_rldh(wr_pend_ff & (idx_ff == `TCP_IDX_T0_RLDH)),
        .i_we_rldl(wr_pend_ff & (idx_ff == `TCP_IDX_T0_RLDL)),
        .o_ctl(ctl0),
        .o_cmp(cmp0),
        .o_rld(rld0),
        .o_cnt(cnt0),
        .o_tout(O_TOUT0),
        .o_capflag(cap0),
        .o_ev_reload(ev0[0]),
        .o_ev_compare(ev0[1]),
        .o_ev_capture(ev0[2])
    );

    tcp_timer_ch u_ch1
    (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_tin(tin1_sync_ff[1]),
        .i_wdata(wd),
        .i_we_ctl(wr_pend_ff & (idx_ff == `TCP_IDX_T1_CTL1)),
        .i_we_cmph(wr_pend_ff & (idx_ff == `TCP_IDX_T1_CMPH)),
        .i_we_cmpl(wr_pend_ff & (idx_ff == `TCP_IDX_T1_CMPL)),
        .i_we_rldh(wr_pend_ff & (idx_ff == `TCP_IDX_T1_RLDH)),
        .i_we_rldl(wr_pend_ff & (idx_ff == `TCP_IDX_T1_RLDL)),
        .o_ctl(ctl1),
        .o_cmp(cmp1),
        .o_rld(rld1),
        .o_cnt(cnt1),
        .o_tout(O_TOUT1),
        .o_capflag(cap1),
        .o_ev_reload(ev1[0]),
        .o_ev_compare(ev1[1]),
        .o_ev_capture(ev1[2])
    );

    // sticky events per timer nibble; the capture flag bit is live state, not sticky
    assign ev_set = {1'b0, ev1, 1'b0, ev0};

    // write-one-to-clear, but a new event in the same cycle keeps its bit set
    always @*
    begin
        nxt_status = status_ff;
        if (wr_pend_ff & (idx_ff == `TCP_IDX_STATUS))
            nxt_status = status_ff & ~wd;
        nxt_status = nxt_status | ev_set;
        nxt_status[`TCP_ST_CAPFLAG] = cap0;
        nxt_status[`TCP_ST_T1_BASE + `TCP_ST_CAPFLAG] = cap1;
    end

    // status, mask and registered interrupt level
    always @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            status_ff <= `TCP_RST_BYTE;
            mask_ff <= `TCP_RST_BYTE;
            irq_ff <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status;
            if (wr_pend_ff & (idx_ff == `TCP_IDX_MASK))
                mask_ff <= wd;
            irq_ff <= |(status_ff & mask_ff & `TCP_ST_IRQ_MASK);
        end
    end

    assign O_HRDATA = hrdata_ff;
    assign O_HREADYOUT = ~rd_pend_ff;
    assign O_HRESP = 1'b0;
    assign O_IRQ = irq_ff;
endmodule

// ---- verification/tcp_timer_assertions.sv ----
// concurrent checks on the ports of the dual timer block
`timescale 1ns/100ps
`include "tcp_regs.vh"
module tcp_timer_assertions
(
    input logic I_CLK_SYS,
    input logic I_ARST_N,
    input logic I_HSEL,
    input logic [31:0] I_HADDR,
    input logic [1:0] I_HTRANS,
    input logic I_HWRITE,
    input logic [2:0] I_HSIZE,
    input logic [31:0] I_HWDATA,
    input logic I_HREADY,
    input logic I_TIN0,
    input logic I_TIN1,
    input logic [31:0] O_HRDATA,
    input logic O_HREADYOUT,
    input logic O_HRESP,
    input logic O_TOUT0,
    input logic O_TOUT1,
    input logic O_IRQ
);
    logic wr_ff;
    logic [31:0] adr_ff;
    logic [7:0] ctl0_ff;
    logic [7:0] mask_ff;
    wire taken = I_HSEL && I_HTRANS[1] && I_HREADY;
    wire rd_take = taken && !I_HWRITE;
    wire rd_ok = rd_take && I_HADDR[31:14] == 18'h0 && I_HADDR[1:0] == 2'h0;

    // shadow copies follow bus writes, so pin checks need no view inside the block
    always @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            wr_ff <= 1'h0;
            adr_ff <= 32'h0;
            ctl0_ff <= 8'h00;
            mask_ff <= 8'h00;
        end
        else
        begin
            if (wr_ff && I_HREADY && adr_ff == {18'h0, `TCP_IDX_T0_CTL1, 2'h0})
                ctl0_ff <= I_HWDATA[7:0];
            if (wr_ff && I_HREADY && adr_ff == {18'h0, `TCP_IDX_MASK, 2'h0})
                mask_ff <= I_HWDATA[7:0];
            if (taken)
                wr_ff <= I_HWRITE;
            else if (I_HREADY)
                wr_ff <= 1'h0;
            if (taken)
                adr_ff <= I_HADDR;
        end
    end

    default clocking dc @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_ARST_N);

    // bus handshake shape
    resp_okay_a: assert property (O_HRESP == 1'h0)
        else $error("response not okay");
    one_wait_a: assert property (!O_HREADYOUT |=> O_HREADYOUT)
        else $error("wait longer than one cycle");
    read_wait_a: assert property (rd_ok |=> !O_HREADYOUT ##1 O_HREADYOUT)
        else $error("read without exactly one wait");
    write_fast_a: assert property (taken && I_HWRITE |=> O_HREADYOUT)
        else $error("write data phase stalled");
    wait_cause_a: assert property ($fell(O_HREADYOUT) |-> $past(rd_take))
        else $error("wait state without a read");
    rdata_clean_a: assert property ($rose(O_HREADYOUT) |-> O_HRDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    // a stopped timer parks its pin at the polarity level
    idle_level_a:
        assert property ($stable(ctl0_ff) && !ctl0_ff[7] |-> O_TOUT0 == ctl0_ff[6])
        else $error("disabled output not at polarity level");
    // mask of zero keeps the interrupt quiet one cycle on
    irq_quiet_a: assert property ($past(mask_ff) == 8'h00 |-> !O_IRQ)
        else $error("interrupt with all events masked");

    cover property (rd_ok);
    cover property ($rose(O_IRQ));
    cover property ($changed(O_TOUT1));
endmodule

// ---- verification/tcp_pin_drv.sv ----
// outside world of the timer input pins
`timescale 1ns/100ps
module tcp_pin_drv
(
    input logic i_clk,
    input logic i_arst_n,
    input logic [1:0] i_lvl,
    output logic o_tin0,
    output logic o_tin1
);
    logic [1:0] pin_ff;

    // push-pull source, never released; the bench spaces edges so sync flops see each one
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pin_ff <= 2'h0;
        else
            pin_ff <= i_lvl;
    end
    assign o_tin0 = pin_ff[0];
    assign o_tin1 = pin_ff[1];
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the dual timer block
`timescale 1ns/100ps
`include "tcp_regs.vh"
module tb;
    localparam logic [11:0] ix_c0 = `TCP_IDX_T0_CTL1;
    localparam logic [11:0] ix_st = `TCP_IDX_STATUS;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] lvl = 2'h0;
    logic rd_ph = 1'h0;
    logic [31:0] rdv;
    logic [7:0] rnd = 8'h5F;
    logic [27:0] ent;
    logic [27:0] exp_q[$];
    logic [15:0] cap;
    logic v;
    wire hready;
    wire [31:0] hrdata;
    wire tin0, tin1, tout0, tout1, irq;
    integer miscompares = 0;
    integer check_count = 0;
    integer i, t, a, b;

    tcp_timer dut_u (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hready), .I_TIN0(tin0), .I_TIN1(tin1), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(), .O_TOUT0(tout0), .O_TOUT1(tout1), .O_IRQ(irq));
    tcp_pin_drv pin_u (.i_clk(clk), .i_arst_n(arst_n), .i_lvl(lvl), .o_tin0(tin0),
        .o_tin1(tin1));

    always #50 clk = ~clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task stop_test(input logic to);
        begin
            if (to || exp_q.size() != 0)
                miscompares = miscompares + 1;
            $display("checks %0d miscompares %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e)
            begin
                miscompares = miscompares + 1;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask

    // ready is sampled mid-cycle, where it has settled, then the edge is taken
    task wrdy;
        integer n;
        begin
            n = 0;
            @(negedge clk);
            while (hready !== 1'h1)
            begin
                n = n + 1;
                if (n > 20)
                    stop_test(1'h1);
                @(negedge clk);
            end
            rdv = hrdata;
            @(posedge clk);
        end
    endtask

    task bus(input logic w, input logic [11:0] ix, input logic [7:0] d);
        begin
            hsel <= 1'h1;
            haddr <= {18'h0, ix, 2'h0};
            hwrite <= w;
            htrans <= 2'h2;
            wrdy;
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            rd_ph = !w;
            wrdy;
            rd_ph = 1'h0;
        end
    endtask

    task wr(input logic [11:0] ix, input logic [7:0] d);
        bus(1'h1, ix, d);
    endtask

    task rd(input logic [11:0] ix, input logic [7:0] e, input logic [7:0] m);
        begin
            exp_q.push_back({ix, m, e});
            bus(1'h0, ix, 8'h00);
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask

    // pins are registered, so look a few cycles after the cause
    task pchk(input string nm, input integer s, input logic e);
        begin
            repeat (3) @(negedge clk);
            chk(nm, {31'h0, e}, {31'h0, s == 0 ? tout0 : s == 1 ? tout1 : irq});
            @(posedge clk);
        end
    endtask

    // cycles between two changes of a timer pin
    task tgl(input integer s, output integer n);
        logic v0;
        begin
            n = 1;
            @(negedge clk);
            v0 = s ? tout1 : tout0;
            while ((s ? tout1 : tout0) === v0)
            begin
                n = n + 1;
                if (n > 700)
                    stop_test(1'h1);
                @(negedge clk);
            end
        end
    endtask

    // each completed read is matched against the oldest note
    always @(negedge clk)
    begin
        if (rd_ph && hready === 1'h1 && exp_q.size() > 0)
        begin
            ent = exp_q.pop_front();
            chk($sformatf("reg_%h", ent[27:16]), {24'h0, ent[7:0] & ent[15:8]},
                hrdata & {24'hFFFFFF, ent[15:8]});
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'h1;
        @(posedge clk);
        wr(12'hF06, 8'hA5);
        rd(ix_c0, 8'h00, 8'hFF);
        rd(`TCP_IDX_T0_CMPL, 8'h00, 8'hFF);
        rd(`TCP_IDX_T1_CMPL, 8'h00, 8'hFF);
        rd(12'hF06, 8'h00, 8'hFF);
        for (i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            wr(`TCP_IDX_T1_CTL1, rnd & 8'h7F);
            rd(`TCP_IDX_T1_CTL1, rnd & 8'h7F, 8'hFF);
        end
        wr(ix_c0, 8'h41);
        pchk("tout0", 0, 1'h1);
        wr(ix_c0, 8'h01);
        pchk("tout0", 0, 1'h0);
        rd(`TCP_IDX_T0_CNTL, 8'h00, 8'hFF);
        wr(`TCP_IDX_T0_RLDH, 8'h00);
        wr(`TCP_IDX_T0_RLDL, 8'h02);
        for (i = 0; i < 3; i++)
        begin
            a = i == 0 ? 0 : i + 5;
            wr(ix_c0, {2'h2, a[2:0], 3'h1});
            tgl(0, t);
            tgl(0, t);
            tgl(0, t);
            chk("period", 2 << a, t);
            @(posedge clk);
        end
        rd(ix_c0, 8'hB9, 8'hFF);
        rd(ix_st, 8'h01, 8'h01);
        pchk("irq", 2, 1'h0);
        wr(`TCP_IDX_MASK, 8'h01);
        pchk("irq", 2, 1'h1);
        wr(ix_c0, 8'h00);
        wr(ix_st, 8'hFF);
        rd(ix_st, 8'h00, 8'h77);
        pchk("irq", 2, 1'h0);
        // capture: reload of 0x0100 lets a later reload clear the flag
        wr(`TCP_IDX_T0_RLDH, 8'h01);
        wr(`TCP_IDX_T0_RLDL, 8'h00);
        wr(ix_c0, 8'h84);
        cyc(20);
        lvl <= 2'h1;
        cyc(6);
        rd(ix_st, 8'h0C, 8'h0C);
        bus(1'h0, `TCP_IDX_T0_CMPH, 8'h00);
        cap[15:8] = rdv[7:0];
        bus(1'h0, `TCP_IDX_T0_CMPL, 8'h00);
        cap[7:0] = rdv[7:0];
        chk("capture", 32'h1, {31'h0, cap >= 16'h0010 && cap <= 16'h0030});
        lvl <= 2'h0;
        cyc(300);
        rd(ix_st, 8'h01, 8'h09);
        wr(ix_c0, 8'h00);
        wr(`TCP_IDX_T0_RLDL, 8'h08);
        wr(`TCP_IDX_T0_CMPH, 8'h01);
        wr(`TCP_IDX_T0_CMPL, 8'h03);
        wr(ix_c0, 8'h83);
        tgl(0, t);
        tgl(0, a);
        tgl(0, b);
        chk("pwm", 32'h1, {31'h0, (a == 6 && b == 258) || (a == 258 && b == 6)});
        @(posedge clk);
        rd(ix_st, 8'h02, 8'h02);
        // counter on falling edges of input 1, reload every second count
        wr(`TCP_IDX_T1_RLDH, 8'h00);
        wr(`TCP_IDX_T1_RLDL, 8'h02);
        wr(`TCP_IDX_T1_CTL1, 8'hC2);
        @(negedge clk);
        v = tout1;
        @(posedge clk);
        for (i = 1; i < 4; i++)
        begin
            lvl <= 2'h2;
            cyc(8);
            rd(`TCP_IDX_T1_CNTL, 8'(i - 1), 8'hFF);
            lvl <= 2'h0;
            cyc(8);
            rd(`TCP_IDX_T1_CNTL, i == 3 ? 8'h01 : 8'(i), 8'hFF);
            pchk("tout1", 1, i == 3 ? !v : v);
        end
        // one-shot on timer 1: two steps to reload, then enable drops and count holds
        wr(ix_st, 8'h10);
        wr(`TCP_IDX_T1_CTL1, 8'h80);
        cyc(4);
        rd(`TCP_IDX_T1_CTL1, 8'h00, 8'h80);
        rd(ix_st, 8'h10, 8'h10);
        cyc(4);
        rd(`TCP_IDX_T1_CNTL, 8'h01, 8'hFF);
        pchk("tout1", 1, 1'h0);
        stop_test(1'h0);
    end
endmodule

bind tcp_timer tcp_timer_assertions chk_u (.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N),
    .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .I_TIN0(I_TIN0),
    .I_TIN1(I_TIN1), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .O_TOUT0(O_TOUT0), .O_TOUT1(O_TOUT1), .O_IRQ(O_IRQ));
